// ===== mgio_board.sv
`timescale 1ns/1ps
// Board side of the pads: loads with pull-ups, push-button and bench sources
module mgio_board (
    input wire logic [23:0] pin_out_i,
    input wire logic [23:0] pin_oe_i,
    input wire logic [23:0] ext_lvl_i,
    input wire logic [23:0] ext_en_i,
    output logic [23:0] pin_level_o
);
    // Port drive first, then an external source, else the pull-up level
    always_comb begin
        for (int i = 0; i < 24; i++) begin
            if (pin_oe_i[i]) begin
                pin_level_o[i] = pin_out_i[i];
            end else if (ext_en_i[i]) begin
                pin_level_o[i] = ext_lvl_i[i];
            end else begin
                pin_level_o[i] = 1'b1;
            end
        end
    end
endmodule : mgio_board

// ===== mgio_pkg.sv
package mgio_pkg;

    // Pin count across the three eight-bit groups
    localparam int unsigned MGIO_PINS = 24;
    localparam int unsigned MGIO_GRP_W = 8;
    localparam int unsigned MGIO_SEL_W = 3;
    localparam int unsigned MGIO_SLOTS = 12;
    localparam int unsigned MGIO_SEG_W = 5;

    // Special-function register addresses
    localparam logic [7:0] MGIO_ADDR_DATA0 = 8'h80;
    localparam logic [7:0] MGIO_ADDR_DATA1 = 8'h90;
    localparam logic [7:0] MGIO_ADDR_DIR1 = 8'h91;
    localparam logic [7:0] MGIO_ADDR_DATA2 = 8'ha0;
    localparam logic [7:0] MGIO_ADDR_DIR2 = 8'ha1;
    localparam logic [7:0] MGIO_ADDR_DIR0 = 8'ha2;

    // Resource selector bytes in I/O RAM
    localparam logic [15:0] MGIO_SEL_BASE = 16'h2009;
    localparam logic [15:0] MGIO_SEL_LAST = 16'h200e;
    localparam int unsigned MGIO_SEL_LO = 0;
    localparam int unsigned MGIO_SEL_HI = 4;

    // Reset values
    localparam logic [23:0] MGIO_DIR_RST = 24'h00_0000;
    localparam logic [23:0] MGIO_DATA_RST = 24'h00_0000;
    localparam logic [2:0] MGIO_SEL_RST = 3'h0;

    // Implemented pins: push-button 0, pins 1,2,4..11,14..17
    localparam logic [23:0] MGIO_PIN_MASK = 24'h03_cff7;
    // Pins with a direction bit (push-button excluded)
    localparam logic [23:0] MGIO_DIR_MASK = 24'h03_cff6;
    // Dual-use segment pins 4..11 and 14..17
    localparam logic [23:0] MGIO_DUAL_MASK = 24'h03_cff0;

    // Special pin indices
    localparam int unsigned MGIO_PIN_PB = 0;
    localparam int unsigned MGIO_PIN_ORX = 1;
    localparam int unsigned MGIO_PIN_OTX = 2;
    localparam int unsigned MGIO_PIN_SCK = 4;
    localparam int unsigned MGIO_PIN_SDA = 5;
    localparam int unsigned MGIO_PIN_PULSE = 6;

    // Resource selector codes
    localparam logic [2:0] MGIO_RES_NONE = 3'h0;
    localparam logic [2:0] MGIO_RES_RSVD = 3'h1;
    localparam logic [2:0] MGIO_RES_CNT0 = 3'h2;
    localparam logic [2:0] MGIO_RES_CNT1 = 3'h3;
    localparam logic [2:0] MGIO_RES_HI_RISE = 3'h4;
    localparam logic [2:0] MGIO_RES_LO_RISE = 3'h5;
    localparam logic [2:0] MGIO_RES_HI_FALL = 3'h6;
    localparam logic [2:0] MGIO_RES_LO_FALL = 3'h7;

endpackage : mgio_pkg

// ===== mgio_port.sv
`timescale 1ns/1ps
// Behaviour
// - Reset leaves every pin an input, except pins 2, 4, 5 when owned by alternate functions
// - Direction bit 0 input, 1 output
// - Three-bit resource selector per routable pin
// - Codes 0 none, 1 reserved, 2/3 counters
// - Codes 4-7 pick interrupt and edge
// - Pins sharing a resource are ORed
// - Routing samples pin even when output
// - Routing only push-button and pins 1-11
// - Data groups at 0x80, 0x90, 0xA0
// - Direction groups at 0xA2, 0x91, 0xA1
// - Segment count picks segment or general pins
// - Pin 6 carries energy pulse when selected and its direction bit is 1
// - Pins 4/5 serve serial memory link
// - Push-button is input only
// - Optical pins reusable as pins 2, 1
module mgio_port
    import mgio_pkg::*;
(
    input wire logic clk_i,
    input wire logic arst_n_i,
    // Special-function register port
    input wire logic [7:0] sfr_addr_i,
    input wire logic sfr_wr_i,
    input wire logic sfr_rd_i,
    input wire logic [7:0] sfr_wdata_i,
    output logic [7:0] sfr_rdata_o,
    // I/O RAM port for the resource selectors
    input wire logic [15:0] ioram_addr_i,
    input wire logic ioram_wr_i,
    input wire logic ioram_rd_i,
    input wire logic [7:0] ioram_wdata_i,
    output logic [7:0] ioram_rdata_o,
    // Pin-sharing configuration
    input wire logic [4:0] segment_count_setting_i,
    input wire logic pulse_output_select_i,
    input wire logic eeprom_select_i,
    input wire logic optical_tx_gpio_i,
    input wire logic optical_rx_gpio_i,
    // Alternate functions
    input wire logic energy_pulse_output_i,
    input wire logic optical_uart_tx_i,
    output logic optical_uart_rx_o,
    input wire logic eeprom_sck_i,
    input wire logic eeprom_sda_out_i,
    input wire logic eeprom_sda_oe_i,
    output logic eeprom_sda_in_o,
    // Pads
    input wire logic [23:0] pin_in_i,
    output logic [23:0] pin_out_o,
    output logic [23:0] pin_oe_o,
    output logic [23:0] pin_segment_o,
    // Internal resources
    output logic counter_zero_clock_o,
    output logic counter_one_clock_o,
    output logic high_priority_pin_irq_o,
    output logic low_priority_pin_irq_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    // Selector equals one resource code
    function automatic logic sel_is(input logic [2:0] sel, input logic [2:0] code);
        sel_is = (sel == code);
    endfunction : sel_is

    // Dual-use pins in order 4..11,14..17 become segments below the count
    function automatic logic [23:0] seg_mask(input logic [4:0] cnt);
        logic [23:0] m;
        logic [4:0] k;
        m = '0;
        k = '0;
        for (int p = 0; p < MGIO_PINS; p++) begin
            if (MGIO_DUAL_MASK[p]) begin
                m[p] = (k < cnt);
                k = k + 5'h1;
            end
        end
        seg_mask = m;
    endfunction : seg_mask

    ////////////////////////////////////////////////////////////////////////////
    // State
    logic [23:0] dir_r;
    logic [23:0] data_r;
    logic [2:0] sel_r [MGIO_SLOTS];
    logic [23:0] pin_sync;
    logic [23:0] pin_rise;
    logic [23:0] pin_fall;
    logic [23:0] gpio_en;
    logic [23:0] seg_en;
    logic [MGIO_SLOTS-1:0] hit_cnt0;
    logic [MGIO_SLOTS-1:0] hit_cnt1;
    logic [MGIO_SLOTS-1:0] hit_hi;
    logic [MGIO_SLOTS-1:0] hit_lo;
    logic sel_wr_hit;
    logic [15:0] sel_off;

    ////////////////////////////////////////////////////////////////////////////
    // Pad synchroniser, sampled regardless of direction
    mgio_sync #(
        .W(MGIO_PINS)
    ) u_sync (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .d_i(pin_in_i),
        .q_o(pin_sync),
        .rise_o(pin_rise),
        .fall_o(pin_fall)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Direction registers; push-button bit has none
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            dir_r <= MGIO_DIR_RST;
        end else if (sfr_wr_i) begin
            case (sfr_addr_i)
                MGIO_ADDR_DIR0: dir_r[7:0] <= sfr_wdata_i & MGIO_DIR_MASK[7:0];
                MGIO_ADDR_DIR1: dir_r[15:8] <= sfr_wdata_i & MGIO_DIR_MASK[15:8];
                MGIO_ADDR_DIR2: dir_r[23:16] <= sfr_wdata_i & MGIO_DIR_MASK[23:16];
                default: dir_r <= dir_r;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output data latches
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            data_r <= MGIO_DATA_RST;
        end else if (sfr_wr_i) begin
            case (sfr_addr_i)
                MGIO_ADDR_DATA0: data_r[7:0] <= sfr_wdata_i & MGIO_DIR_MASK[7:0];
                MGIO_ADDR_DATA1: data_r[15:8] <= sfr_wdata_i & MGIO_DIR_MASK[15:8];
                MGIO_ADDR_DATA2: data_r[23:16] <= sfr_wdata_i & MGIO_DIR_MASK[23:16];
                default: data_r <= data_r;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register read: outputs show latch, inputs show synchronised pad
    logic [23:0] rd_view;
    assign rd_view = ((dir_r & data_r) | (~dir_r & pin_sync)) & MGIO_PIN_MASK;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sfr_rdata_o <= 8'h00;
        end else if (sfr_rd_i) begin
            case (sfr_addr_i)
                MGIO_ADDR_DATA0: sfr_rdata_o <= rd_view[7:0];
                MGIO_ADDR_DATA1: sfr_rdata_o <= rd_view[15:8];
                MGIO_ADDR_DATA2: sfr_rdata_o <= rd_view[23:16];
                MGIO_ADDR_DIR0: sfr_rdata_o <= dir_r[7:0];
                MGIO_ADDR_DIR1: sfr_rdata_o <= dir_r[15:8];
                MGIO_ADDR_DIR2: sfr_rdata_o <= dir_r[23:16];
                default: sfr_rdata_o <= 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Resource selectors: two per I/O RAM byte, low nibble first
    assign sel_off = ioram_addr_i - MGIO_SEL_BASE;
    assign sel_wr_hit = (ioram_addr_i >= MGIO_SEL_BASE) && (ioram_addr_i <= MGIO_SEL_LAST);

    generate
        for (genvar s = 0; s < MGIO_SLOTS; s++) begin : g_sel
            localparam logic [15:0] BYTE_OFF = 16'(s / 2);
            localparam int unsigned LSB = (s % 2 == 0) ? MGIO_SEL_LO : MGIO_SEL_HI;
            always_ff @(posedge clk_i or negedge arst_n_i) begin
                if (!arst_n_i) begin
                    sel_r[s] <= MGIO_SEL_RST;
                end else if (ioram_wr_i && sel_wr_hit && sel_off == BYTE_OFF) begin
                    sel_r[s] <= ioram_wdata_i[LSB +: MGIO_SEL_W];
                end
            end
        end
    endgenerate

    // Selector read-back, unused bits zero
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ioram_rdata_o <= 8'h00;
        end else if (ioram_rd_i) begin
            ioram_rdata_o <= 8'h00;
            for (int b = 0; b < MGIO_SLOTS / 2; b++) begin
                if (sel_wr_hit && sel_off == 16'(b)) begin
                    ioram_rdata_o <= {1'b0, sel_r[2 * b + 1], 1'b0, sel_r[2 * b]};
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin role: segment driver or general pin
    assign seg_en = seg_mask(segment_count_setting_i) & MGIO_DUAL_MASK;
    assign gpio_en = MGIO_PIN_MASK & ~seg_en;

    ////////////////////////////////////////////////////////////////////////////
    // Per-slot resource hits; slot index equals pin index, slot 3 unused pin
    generate
        for (genvar s = 0; s < MGIO_SLOTS; s++) begin : g_route
            logic live;
            assign live = gpio_en[s];
            assign hit_cnt0[s] = live && sel_is(sel_r[s], MGIO_RES_CNT0) && pin_sync[s];
            assign hit_cnt1[s] = live && sel_is(sel_r[s], MGIO_RES_CNT1) && pin_sync[s];
            assign hit_hi[s] = live && ((sel_is(sel_r[s], MGIO_RES_HI_RISE) && pin_rise[s])
                || (sel_is(sel_r[s], MGIO_RES_HI_FALL) && pin_fall[s]));
            assign hit_lo[s] = live && ((sel_is(sel_r[s], MGIO_RES_LO_RISE) && pin_rise[s])
                || (sel_is(sel_r[s], MGIO_RES_LO_FALL) && pin_fall[s]));
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Combined resource outputs
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            counter_zero_clock_o <= 1'b0;
            counter_one_clock_o <= 1'b0;
            high_priority_pin_irq_o <= 1'b0;
            low_priority_pin_irq_o <= 1'b0;
        end else begin
            counter_zero_clock_o <= |hit_cnt0;
            counter_one_clock_o <= |hit_cnt1;
            high_priority_pin_irq_o <= |hit_hi;
            low_priority_pin_irq_o <= |hit_lo;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pad drive with alternate functions
    logic [23:0] out_nxt;
    logic [23:0] oe_nxt;

    always_comb begin
        out_nxt = data_r;
        oe_nxt = dir_r & gpio_en;
        // Optical transmit owns pin 2 unless released
        if (!optical_tx_gpio_i) begin
            out_nxt[MGIO_PIN_OTX] = optical_uart_tx_i;
            oe_nxt[MGIO_PIN_OTX] = 1'b1;
        end
        // Optical receive owns pin 1 unless released
        if (!optical_rx_gpio_i) begin
            oe_nxt[MGIO_PIN_ORX] = 1'b0;
        end
        // Energy pulse replaces pin 6 data
        if (dir_r[MGIO_PIN_PULSE] && pulse_output_select_i) begin
            out_nxt[MGIO_PIN_PULSE] = energy_pulse_output_i;
        end
        // Serial memory link on pins 4 and 5
        if (eeprom_select_i) begin
            out_nxt[MGIO_PIN_SCK] = eeprom_sck_i;
            oe_nxt[MGIO_PIN_SCK] = gpio_en[MGIO_PIN_SCK];
            out_nxt[MGIO_PIN_SDA] = eeprom_sda_out_i;
            oe_nxt[MGIO_PIN_SDA] = eeprom_sda_oe_i && gpio_en[MGIO_PIN_SDA];
        end
        // Segment pins are never driven here
        oe_nxt = oe_nxt & ~seg_en;
        out_nxt = out_nxt & MGIO_PIN_MASK;
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pin_out_o <= '0;
            pin_oe_o <= '0;
            pin_segment_o <= '0;
        end else begin
            pin_out_o <= out_nxt;
            pin_oe_o <= oe_nxt & MGIO_DIR_MASK;
            pin_segment_o <= seg_en;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Received levels for alternate-function users
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            optical_uart_rx_o <= 1'b0;
            eeprom_sda_in_o <= 1'b0;
        end else begin
            optical_uart_rx_o <= pin_sync[MGIO_PIN_ORX];
            eeprom_sda_in_o <= pin_sync[MGIO_PIN_SDA];
        end
    end

endmodule : mgio_port

// ===== mgio_port_properties.sv
`timescale 1ns/1ps
// Port-level checks of the pin block
module mgio_port_properties
    import mgio_pkg::*;
(
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic [7:0] sfr_addr_i,
    input wire logic sfr_wr_i,
    input wire logic sfr_rd_i,
    input wire logic [7:0] sfr_wdata_i,
    input wire logic [7:0] sfr_rdata_o,
    input wire logic [15:0] ioram_addr_i,
    input wire logic ioram_rd_i,
    input wire logic [7:0] ioram_rdata_o,
    input wire logic [4:0] segment_count_setting_i,
    input wire logic pulse_output_select_i,
    input wire logic eeprom_select_i,
    input wire logic eeprom_sck_i,
    input wire logic optical_rx_gpio_i,
    input wire logic energy_pulse_output_i,
    input wire logic [23:0] pin_in_i,
    input wire logic [23:0] pin_out_o,
    input wire logic [23:0] pin_oe_o,
    input wire logic [23:0] pin_segment_o,
    input wire logic high_priority_pin_irq_o,
    input wire logic low_priority_pin_irq_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!arst_n_i);
    ////////////////////////////////////////////////////////////////////////////////
    AST_RST_INPUT: assert property ($rose(arst_n_i) |-> (pin_oe_o & 24'h03_cfc0) == 24'h0)
        else $error("pin driven right after reset");
    AST_PB_INPUT: assert property (!pin_oe_o[0])
        else $error("push-button pin driven");
    AST_DIR_WRITE: assert property (sfr_wr_i && sfr_addr_i == MGIO_ADDR_DIR0
        && segment_count_setting_i == 5'h0 ##1 !sfr_wr_i |-> ##1 pin_oe_o[7] == $past(sfr_wdata_i[7], 2))
        else $error("direction write not applied to pin 7");
    AST_HI_CAUSE: assert property (high_priority_pin_irq_o |-> $past(pin_in_i, 3) != $past(pin_in_i, 4)
        || $past(pin_in_i, 2) != $past(pin_in_i, 3) || $past(pin_in_i, 4) != $past(pin_in_i, 5))
        else $error("high irq without pad edge");
    AST_LO_CAUSE: assert property (low_priority_pin_irq_o |-> $past(pin_in_i, 3) != $past(pin_in_i, 4)
        || $past(pin_in_i, 2) != $past(pin_in_i, 3) || $past(pin_in_i, 4) != $past(pin_in_i, 5))
        else $error("low irq without pad edge");
    AST_SFR_UNMAPPED: assert property (sfr_rd_i && sfr_addr_i == 8'h81 |=> sfr_rdata_o == 8'h0)
        else $error("unmapped register read not zero");
    AST_IORAM_UNMAPPED: assert property (ioram_rd_i && ioram_addr_i == 16'h200f |=> ioram_rdata_o == 8'h0)
        else $error("selector read past last byte not zero");
    AST_RDATA_HOLD: assert property (!sfr_rd_i |=> $stable(sfr_rdata_o))
        else $error("read data changed without read");
    AST_SEG_ALL: assert property (segment_count_setting_i >= 5'd12 && $past(segment_count_setting_i) >= 5'd12
        |-> (pin_segment_o & MGIO_DUAL_MASK) == MGIO_DUAL_MASK)
        else $error("dual pins not all segments");
    AST_PULSE: assert property (pulse_output_select_i && $past(pulse_output_select_i) && pin_oe_o[6]
        |-> pin_out_o[6] == $past(energy_pulse_output_i))
        else $error("pin 6 not carrying energy pulse");
    AST_SCK: assert property (eeprom_select_i && $past(eeprom_select_i)
        && $past(segment_count_setting_i) == 5'h0 |-> pin_oe_o[4] && pin_out_o[4] == $past(eeprom_sck_i))
        else $error("pin 4 not carrying serial clock");
    AST_RX_IN: assert property (!optical_rx_gpio_i && !$past(optical_rx_gpio_i) |-> !pin_oe_o[1])
        else $error("optical receive pin driven");
endmodule : mgio_port_properties
////////////////////////////////////////////////////////////////////////////////
bind mgio_port mgio_port_properties u_props (.clk_i, .arst_n_i, .sfr_addr_i, .sfr_wr_i, .sfr_rd_i,
    .sfr_wdata_i, .sfr_rdata_o, .ioram_addr_i, .ioram_rd_i, .ioram_rdata_o, .segment_count_setting_i,
    .pulse_output_select_i, .eeprom_select_i, .eeprom_sck_i, .optical_rx_gpio_i, .energy_pulse_output_i,
    .pin_in_i, .pin_out_o, .pin_oe_o, .pin_segment_o, .high_priority_pin_irq_o, .low_priority_pin_irq_o);

// ===== mgio_port_tb.sv
`timescale 1ns/1ps
// Self-checking bench for the pin block
module mgio_port_tb;
    import mgio_pkg::*;
    logic clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic [7:0] sfr_addr_i = '0, sfr_wdata_i = '0, ioram_wdata_i = '0, sfr_rdata_o, ioram_rdata_o;
    logic sfr_wr_i = 0, sfr_rd_i = 0, ioram_wr_i = 0, ioram_rd_i = 0;
    logic [15:0] ioram_addr_i = '0;
    logic [4:0] seg_n = '0;
    logic pulse_sel = 0, ee_sel = 0, otx_gpio = 1, orx_gpio = 1, epulse = 0, utx = 0;
    logic ee_sck = 0, ee_sda = 0, ee_oe = 0, urx, sda_in, cnt0, cnt1, irq_hi, irq_lo;
    logic [23:0] pin_in, pin_out, pin_oe, pin_seg, ext_lvl = '0, ext_en = '0;
    int num_errors = 0, n_checks = 0, cycles = 0, hi, lo;
    logic [7:0] q;
    mgio_port dut (.clk_i, .arst_n_i, .sfr_addr_i, .sfr_wr_i, .sfr_rd_i, .sfr_wdata_i, .sfr_rdata_o,
        .ioram_addr_i, .ioram_wr_i, .ioram_rd_i, .ioram_wdata_i, .ioram_rdata_o,
        .segment_count_setting_i(seg_n), .pulse_output_select_i(pulse_sel), .eeprom_select_i(ee_sel),
        .optical_tx_gpio_i(otx_gpio), .optical_rx_gpio_i(orx_gpio), .energy_pulse_output_i(epulse),
        .optical_uart_tx_i(utx), .optical_uart_rx_o(urx), .eeprom_sck_i(ee_sck),
        .eeprom_sda_out_i(ee_sda), .eeprom_sda_oe_i(ee_oe), .eeprom_sda_in_o(sda_in),
        .pin_in_i(pin_in), .pin_out_o(pin_out), .pin_oe_o(pin_oe), .pin_segment_o(pin_seg),
        .counter_zero_clock_o(cnt0), .counter_one_clock_o(cnt1),
        .high_priority_pin_irq_o(irq_hi), .low_priority_pin_irq_o(irq_lo));
    mgio_board u_board (.pin_out_i(pin_out), .pin_oe_i(pin_oe), .ext_lvl_i(ext_lvl),
        .ext_en_i(ext_en), .pin_level_o(pin_in));
    ////////////////////////////////////////////////////////////////////////////////
    // Clock and hang guard
    always #10 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        if (num_errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : report_and_stop
    task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic tick(input int n = 1);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : tick
    // One access on the register port (io=0) or selector port (io=1)
    task automatic bus(input bit io, input bit wr, input logic [15:0] a, input logic [7:0] d);
        sfr_addr_i = a[7:0];
        ioram_addr_i = a;
        sfr_wdata_i = d;
        ioram_wdata_i = d;
        {sfr_wr_i, sfr_rd_i, ioram_wr_i, ioram_rd_i} = {!io && wr, !io && !wr, io && wr, io && !wr};
        tick();
        {sfr_wr_i, sfr_rd_i, ioram_wr_i, ioram_rd_i} = 4'h0;
        tick();
        q = io ? ioram_rdata_o : sfr_rdata_o;
    endtask : bus
    task automatic window();
        hi = 0;
        lo = 0;
        repeat (8) begin
            tick();
            hi += (irq_hi === 1'b1);
            lo += (irq_lo === 1'b1);
        end
    endtask : window
    ////////////////////////////////////////////////////////////////////////////////
    // Reset state and register map
    task automatic t_regs();
        chk("oe after reset", pin_oe & MGIO_DIR_MASK, 24'h0);
        bus(0, 0, MGIO_ADDR_DIR0, 0); chk("dir0", q, 0);
        bus(1, 0, 16'h2009, 0); chk("sel 2009", q, 0);
        bus(0, 1, MGIO_ADDR_DIR0, 8'hff);
        bus(0, 1, MGIO_ADDR_DIR1, 8'hff);
        bus(0, 1, MGIO_ADDR_DIR2, 8'hff);
        bus(0, 0, MGIO_ADDR_DIR0, 0); chk("dir0 ff", q, 8'hf6);
        bus(0, 0, MGIO_ADDR_DIR1, 0); chk("dir1 ff", q, 8'hcf);
        bus(0, 0, MGIO_ADDR_DIR2, 0); chk("dir2 ff", q, 8'h03);
        chk("oe all", pin_oe, MGIO_DIR_MASK);
        bus(0, 1, MGIO_ADDR_DATA1, 8'ha5);
        bus(0, 0, MGIO_ADDR_DATA1, 0); chk("data1", q, 8'h85);
        chk("out group1", pin_out[15:8], 8'h85);
        bus(0, 0, 8'h81, 0); chk("unmapped", q, 0);
        bus(0, 1, MGIO_ADDR_DIR1, 0);
        tick(4);
        bus(0, 0, MGIO_ADDR_DATA1, 0); chk("data1 in", q, 8'hcf);
        bus(0, 1, MGIO_ADDR_DIR0, 8'h80);
        bus(0, 1, MGIO_ADDR_DIR2, 0);
        bus(1, 1, 16'h200e, 8'h77);
        bus(1, 0, 16'h200e, 0); chk("sel 200e", q, 8'h77);
        bus(1, 0, 16'h200f, 0); chk("sel 200f", q, 0);
        bus(1, 1, 16'h200e, 0);
    endtask : t_regs
    // Every selector code on pin 7 driven as an output
    task automatic t_route();
        for (int c = 0; c < 8; c++) begin
            bus(1, 1, 16'h200c, {1'b0, c[2:0], 4'h0});
            bus(0, 1, MGIO_ADDR_DATA0, 8'h80);
            window();
            chk("rise hi", hi, c == 4);
            chk("rise lo", lo, c == 5);
            chk("cnt levels", {cnt1, cnt0}, {c == 3, c == 2});
            bus(0, 1, MGIO_ADDR_DATA0, 8'h00);
            window();
            chk("fall hi", hi, c == 6);
            chk("fall lo", lo, c == 7);
        end
        bus(1, 1, 16'h200c, 0);
    endtask : t_route
    // Shared resources, segment mode and push-button routing
    task automatic t_or();
        bus(1, 1, 16'h200d, 8'h22);
        ext_en[9:8] = 2'b11;
        for (int i = 0; i < 3; i++) begin
            ext_lvl[9:8] = i == 0 ? 2'b01 : i == 1 ? 2'b10 : 2'b00;
            tick(6);
            chk("or cnt0", cnt0, i != 2);
        end
        seg_n = 5'd12;
        ext_lvl[9:8] = 2'b11;
        tick(6);
        chk("seg cnt0", cnt0, 0);
        chk("seg pins", pin_seg, MGIO_DUAL_MASK);
        seg_n = 5'd0;
        tick(2);
        chk("no seg", pin_seg, 0);
        bus(1, 1, 16'h2009, 8'h04);
        ext_en[0] = 1'b1;
        tick(6);
        ext_lvl[0] = 1'b1;
        window();
        chk("button irq", hi, 1);
    endtask : t_or
    // Pulse output, serial memory pins and optical pins
    task automatic t_share();
        bus(0, 1, MGIO_ADDR_DIR0, 8'h40);
        pulse_sel = 1;
        epulse = 1;
        tick(2);
        chk("pulse hi", pin_out[6], 1);
        epulse = 0;
        tick(2);
        chk("pulse lo", pin_out[6], 0);
        ee_sel = 1;
        ee_sck = 1;
        ext_en[5] = 1;
        tick(5);
        chk("sck", {pin_oe[4], pin_out[4], sda_in}, 3'b110);
        ext_lvl[5] = 1;
        tick(5);
        chk("sda in", sda_in, 1);
        otx_gpio = 0;
        orx_gpio = 0;
        ext_en[1] = 1;
        bus(0, 1, MGIO_ADDR_DIR0, 8'h06);
        tick(4);
        chk("opt pins", {pin_oe[2], pin_out[2], pin_oe[1], urx}, 4'b1000);
        ext_lvl[1] = 1;
        tick(5);
        chk("optical_receive_pin", urx, 1);
    endtask : t_share
    // Reset in mid-run returns configured outputs to inputs
    task automatic t_reset();
        {ee_sel, pulse_sel, otx_gpio, orx_gpio} = 4'b0011;
        tick(2);
        chk("oe before reset", pin_oe[2:1], 2'b11);
        arst_n_i = 1'b0;
        tick(2);
        arst_n_i = 1'b1;
        chk("oe in reset", pin_oe, 24'h0);
        tick();
        bus(0, 0, MGIO_ADDR_DIR0, 0); chk("dir0 mid reset", q, 0);
        chk("oe after reset", pin_oe & MGIO_DIR_MASK, 24'h0);
    endtask : t_reset
    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        tick(16);
        arst_n_i = 1'b1;
        tick();
        t_regs();
        t_route();
        t_or();
        t_share();
        t_reset();
        report_and_stop();
    end
endmodule : mgio_port_tb

// ===== mgio_sync.sv
`timescale 1ns/1ps
// Two-flop synchroniser with a third stage for edge detection
module mgio_sync #(
    parameter int unsigned W = 8
) (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o,
    output logic [W-1:0] rise_o,
    output logic [W-1:0] fall_o
);

    logic [W-1:0] meta_r;
    logic [W-1:0] sync_r;
    logic [W-1:0] prev_r;

    ////////////////////////////////////////////////////////////////////////////
    // Synchroniser chain; first stage read only by the second
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            meta_r <= '0;
            sync_r <= '0;
            prev_r <= '0;
        end else begin
            meta_r <= d_i;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Level and edge outputs
    assign q_o = sync_r;
    assign rise_o = sync_r & ~prev_r;
    assign fall_o = ~sync_r & prev_r;

endmodule : mgio_sync
